// ### hw/embp_pkg.sv
// Functional notes
// RL1: Ninety data words serve as storage, message source or response holding area.
// RL2: A target module register selects which remote module a message addresses.
// RL3: Writing the launch register takes the value as message number and sends it.
// RL4: Launch register reads zero idle, negative busy, else response length 1 to 254.
// RL5: Launch register reads 255 without connection; any write clears status and launches.
// RL6: Format write requests code 0=8/8, 1=8/16, 2=16/16, 3=16/8.
// RL7: Format fixes class and instance field lengths, one byte for 8, two for 16.
// RL8: Format write without connection to the selected module opens one.
// RL9: Format write differing from an existing connection's format gives a range error.
// RL10: Format reads actual code in low byte, bit 8 when linked, 255 without connection.
// RL11: A byte buffer holds outgoing message contents and the received reply.
// RL12: The index register points at a buffer byte for typed accesses.
// RL13: Byte, word and long accesses address the buffer at the index from its start.
// RL14: Each write to the six buffer access registers updates the index.
// RL15: Byte write stores one byte at the index, then index grows by 1.
// RL16: Word and long writes advance the index by 2 and 4.
// RL17: Byte 0 is the header rewritten on launch; service, class, instance, attribute follow.
// RL18: Buffer reads leave the index; any buffer access without connection is an error.
// RL19: The index is zero after reset.
// RL20: Software waits for busy to end before a new launch or reading replies.
`default_nettype none
package embp_pkg;
  localparam logic [15:0] REG_DATA_FIRST = 16'h34bc;
  localparam logic [15:0] REG_DATA_LAST = 16'h3515;
  localparam logic [15:0] REG_MODULE = 16'h3516;
  localparam logic [15:0] REG_LAUNCH = 16'h3517;
  localparam logic [15:0] REG_FORMAT = 16'h3518;
  localparam logic [15:0] REG_INDEX = 16'h3519;
  localparam logic [15:0] REG_SERVICE = 16'h351a;
  localparam logic [15:0] REG_CLASS = 16'h351b;
  localparam logic [15:0] REG_INSTANCE = 16'h351c;
  localparam logic [15:0] REG_BYTE = 16'h351d;
  localparam logic [15:0] REG_WORD = 16'h351e;
  localparam logic [15:0] REG_LONG = 16'h351f;
  localparam int unsigned DATA_WORDS = 90;
  localparam logic [31:0] STAT_IDLE = 32'h0000_0000;
  localparam logic [31:0] STAT_BUSY = 32'hffff_ffff;
  localparam logic [31:0] READ_NO_CONN = 32'h0000_00ff;
  localparam int unsigned FMT_LINK_BIT = 8;
  localparam int unsigned BUF_HDR_POS = 0;
  localparam int unsigned BUF_SVC_POS = 1;
  localparam int unsigned BUF_CLS_POS = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    FMT_8_8 = 2'h0,
    FMT_8_16 = 2'h1,
    FMT_16_16 = 2'h2,
    FMT_16_8 = 2'h3
  } embp_fmt_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } embp_state_e;

  function automatic logic [2:0] embp_cls_len(input embp_fmt_e f);
    embp_cls_len = (f == FMT_16_16 || f == FMT_16_8) ? 3'd2 : 3'd1;
  endfunction : embp_cls_len

  function automatic logic [2:0] embp_inst_len(input embp_fmt_e f);
    embp_inst_len = (f == FMT_8_16 || f == FMT_16_16) ? 3'd2 : 3'd1;
  endfunction : embp_inst_len
endpackage : embp_pkg
`default_nettype wire

// ### hw/embp_port.sv
`default_nettype none
module embp_port
  import embp_pkg::*;
#(
  parameter int unsigned IDX_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  output logic send_req_ff,
  output logic [31:0] send_num_ff,
  output logic [31:0] send_module_ff,
  output logic open_req_ff,
  output logic [31:0] open_module_ff,
  output logic [1:0] open_fmt_ff,
  output logic range_err_ff,
  output logic access_err_ff,
  input wire logic send_done,
  input wire logic [7:0] rsp_len,
  input wire logic link_up,
  input wire logic rsp_we,
  input wire logic [IDX_W-1:0] rsp_addr,
  input wire logic [7:0] rsp_wdata,
  input wire logic [IDX_W-1:0] tx_raddr,
  output logic [7:0] tx_rdata_ff
);
  localparam int unsigned BUF_DEPTH = 1 << IDX_W;

  if (IDX_W < 3 || IDX_W > 12) begin : g_bad_idx_w
    $error("IDX_W must lie between 3 and 12");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] data_mem [DATA_WORDS];
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [31:0] module_ff, nxt_module;
  embp_state_e state_ff, nxt_state;
  logic [7:0] rsp_len_ff, nxt_rsp_len;
  logic conn_valid_ff, nxt_conn_valid;
  logic conn_up_ff, nxt_conn_up;
  logic [31:0] conn_mod_ff, nxt_conn_mod;
  embp_fmt_e conn_fmt_ff, nxt_conn_fmt;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic [31:0] nxt_rdata;
  logic nxt_send_req, nxt_open_req, nxt_range_err, nxt_access_err;
  logic [31:0] nxt_send_num, nxt_send_module, nxt_open_module;
  logic [1:0] nxt_open_fmt;
  logic [3:0] bw_en;
  logic [IDX_W-1:0] bw_base;
  logic [31:0] bw_data;
  logic dw_en;
  logic [6:0] dw_idx;
  logic have_conn, is_buf_reg;
  logic [2:0] cls_n, inst_n;
  logic [IDX_W-1:0] cls_pos, inst_pos;

  // Bytes little endian from base, count n, zero above
  function automatic logic [31:0] buf_get(input logic [IDX_W-1:0] base, input logic [2:0] n);
    logic [31:0] v;
    v = RST_WORD;
    for (int k = 0; k < 4; k++) begin
      if (k < int'(n)) begin
        v[8*k +: 8] = buf_mem[IDX_W'(base + IDX_W'(k))];
      end
    end
    return v;
  endfunction : buf_get

  assign have_conn = conn_valid_ff && (conn_mod_ff == module_ff);
  assign is_buf_reg = (reg_addr >= REG_SERVICE) && (reg_addr <= REG_LONG);
  assign dw_idx = 7'(reg_addr - REG_DATA_FIRST);
  assign cls_n = embp_cls_len(conn_fmt_ff); // RL7
  assign inst_n = embp_inst_len(conn_fmt_ff); // RL7
  assign cls_pos = IDX_W'(BUF_CLS_POS); // RL17
  assign inst_pos = IDX_W'(cls_pos + IDX_W'(cls_n)); // RL17

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_module = module_ff;
    nxt_state = state_ff;
    nxt_rsp_len = rsp_len_ff;
    nxt_conn_valid = conn_valid_ff;
    nxt_conn_up = conn_up_ff;
    nxt_conn_mod = conn_mod_ff;
    nxt_conn_fmt = conn_fmt_ff;
    nxt_idx = idx_ff;
    nxt_send_req = 1'b0;
    nxt_send_num = send_num_ff;
    nxt_send_module = send_module_ff;
    nxt_open_req = 1'b0;
    nxt_open_module = open_module_ff;
    nxt_open_fmt = open_fmt_ff;
    nxt_range_err = 1'b0;
    nxt_access_err = 1'b0;
    bw_en = 4'h0;
    bw_base = idx_ff;
    bw_data = reg_wdata;
    dw_en = 1'b0;
    if (send_done && state_ff == ST_BUSY) begin
      nxt_state = ST_DONE;
      nxt_rsp_len = rsp_len;
    end
    if (link_up && conn_valid_ff) begin
      nxt_conn_up = 1'b1;
    end
    if (reg_wr) begin
      if (reg_addr >= REG_DATA_FIRST && reg_addr <= REG_DATA_LAST) begin
        dw_en = 1'b1; // RL1
      end
      if (is_buf_reg && !have_conn) begin
        nxt_access_err = 1'b1; // RL18
      end
      case (reg_addr)
        REG_MODULE: begin
          nxt_module = reg_wdata; // RL2
        end
        REG_LAUNCH: begin
          nxt_state = ST_BUSY; // RL5
          nxt_send_req = 1'b1; // RL3
          nxt_send_num = reg_wdata; // RL3
          nxt_send_module = module_ff;
          bw_en = 4'h1; // RL17
          bw_base = IDX_W'(BUF_HDR_POS);
          bw_data = {24'h00_0000, 2'b00, module_ff[5:0]};
        end
        REG_FORMAT: begin
          if (!have_conn && reg_wdata[31:2] == 30'h0) begin
            nxt_conn_valid = 1'b1; // RL8
            nxt_conn_up = 1'b0;
            nxt_conn_mod = module_ff;
            nxt_conn_fmt = embp_fmt_e'(reg_wdata[1:0]); // RL6
            nxt_open_req = 1'b1; // RL8
            nxt_open_module = module_ff;
            nxt_open_fmt = reg_wdata[1:0];
          end else if (reg_wdata != {30'h0, conn_fmt_ff}) begin
            nxt_range_err = 1'b1; // RL9
          end
        end
        REG_INDEX: begin
          nxt_idx = reg_wdata[IDX_W-1:0]; // RL12
        end
        REG_SERVICE: begin
          if (have_conn) begin
            bw_en = 4'h1;
            bw_base = IDX_W'(BUF_SVC_POS); // RL17
            nxt_idx = IDX_W'(BUF_CLS_POS); // RL14
          end
        end
        REG_CLASS: begin
          if (have_conn) begin
            bw_en = (cls_n == 3'd2) ? 4'h3 : 4'h1;
            bw_base = cls_pos;
            nxt_idx = inst_pos; // RL14
          end
        end
        REG_INSTANCE: begin
          if (have_conn) begin
            bw_en = (inst_n == 3'd2) ? 4'h3 : 4'h1;
            bw_base = inst_pos;
            nxt_idx = IDX_W'(inst_pos + IDX_W'(inst_n)); // RL14
          end
        end
        REG_BYTE: begin
          if (have_conn) begin
            bw_en = 4'h1; // RL13
            nxt_idx = IDX_W'(idx_ff + IDX_W'(1)); // RL15
          end
        end
        REG_WORD: begin
          if (have_conn) begin
            bw_en = 4'h3; // RL13
            nxt_idx = IDX_W'(idx_ff + IDX_W'(2)); // RL16
          end
        end
        REG_LONG: begin
          if (have_conn) begin
            bw_en = 4'hf; // RL13
            nxt_idx = IDX_W'(idx_ff + IDX_W'(4)); // RL16
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd && is_buf_reg && !have_conn) begin
      nxt_access_err = 1'b1; // RL18
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = RST_WORD;
    if (reg_rd) begin
      if (reg_addr >= REG_DATA_FIRST && reg_addr <= REG_DATA_LAST) begin
        nxt_rdata = data_mem[dw_idx]; // RL1
      end
      case (reg_addr)
        REG_MODULE: nxt_rdata = module_ff;
        REG_LAUNCH: begin
          if (!have_conn) begin
            nxt_rdata = READ_NO_CONN; // RL5
          end else begin
            case (state_ff)
              ST_BUSY: nxt_rdata = STAT_BUSY; // RL4
              ST_DONE: nxt_rdata = {24'h00_0000, rsp_len_ff}; // RL4
              default: nxt_rdata = STAT_IDLE; // RL4
            endcase
          end
        end
        REG_FORMAT: begin
          if (!have_conn) begin
            nxt_rdata = READ_NO_CONN; // RL10
          end else begin
            nxt_rdata = {23'h00_0000, conn_up_ff, 6'h00, conn_fmt_ff}; // RL10
          end
        end
        REG_INDEX: nxt_rdata = {{(32 - IDX_W){1'b0}}, idx_ff};
        REG_SERVICE: nxt_rdata = have_conn ? buf_get(IDX_W'(BUF_SVC_POS), 3'd1) : RST_WORD;
        REG_CLASS: nxt_rdata = have_conn ? buf_get(cls_pos, cls_n) : RST_WORD;
        REG_INSTANCE: nxt_rdata = have_conn ? buf_get(inst_pos, inst_n) : RST_WORD;
        REG_BYTE: nxt_rdata = have_conn ? buf_get(idx_ff, 3'd1) : RST_WORD; // RL13
        REG_WORD: nxt_rdata = have_conn ? buf_get(idx_ff, 3'd2) : RST_WORD; // RL13
        REG_LONG: nxt_rdata = have_conn ? buf_get(idx_ff, 3'd4) : RST_WORD; // RL13
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      module_ff <= RST_WORD;
      state_ff <= ST_IDLE;
      rsp_len_ff <= 8'h00;
      conn_valid_ff <= 1'b0;
      conn_up_ff <= 1'b0;
      conn_mod_ff <= RST_WORD;
      conn_fmt_ff <= FMT_8_8;
      idx_ff <= '0; // RL19
      reg_rdata_ff <= RST_WORD;
      send_req_ff <= 1'b0;
      send_num_ff <= RST_WORD;
      send_module_ff <= RST_WORD;
      open_req_ff <= 1'b0;
      open_module_ff <= RST_WORD;
      open_fmt_ff <= 2'h0;
      range_err_ff <= 1'b0;
      access_err_ff <= 1'b0;
      tx_rdata_ff <= 8'h00;
    end else begin
      module_ff <= nxt_module;
      state_ff <= nxt_state;
      rsp_len_ff <= nxt_rsp_len;
      conn_valid_ff <= nxt_conn_valid;
      conn_up_ff <= nxt_conn_up;
      conn_mod_ff <= nxt_conn_mod;
      conn_fmt_ff <= nxt_conn_fmt;
      idx_ff <= nxt_idx;
      reg_rdata_ff <= nxt_rdata;
      send_req_ff <= nxt_send_req;
      send_num_ff <= nxt_send_num;
      send_module_ff <= nxt_send_module;
      open_req_ff <= nxt_open_req;
      open_module_ff <= nxt_open_module;
      open_fmt_ff <= nxt_open_fmt;
      range_err_ff <= nxt_range_err;
      access_err_ff <= nxt_access_err;
      tx_rdata_ff <= buf_mem[tx_raddr];
    end
  end

  // Memories hold no reset; network reply bytes land after software lanes
  always_ff @(posedge clk) begin
    if (dw_en) begin
      data_mem[dw_idx] <= reg_wdata; // RL1
    end
    for (int k = 0; k < 4; k++) begin
      if (bw_en[k]) begin
        buf_mem[IDX_W'(bw_base + IDX_W'(k))] <= bw_data[8*k +: 8]; // RL11
      end
    end
    if (rsp_we) begin
      buf_mem[rsp_addr] <= rsp_wdata; // RL11
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_launch;
    reg_wr && reg_addr == REG_LAUNCH |=> send_req_ff && state_ff == ST_BUSY && send_num_ff == $past(reg_wdata);
  endproperty
  a_launch: assert property (p_launch) else $error("launch write did not start a send"); // RL3

  property p_busy_read;
    reg_rd && reg_addr == REG_LAUNCH && have_conn && state_ff == ST_BUSY |=> reg_rdata_ff == STAT_BUSY;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy status not negative"); // RL4

  property p_noconn_read;
    reg_rd && (reg_addr == REG_LAUNCH || reg_addr == REG_FORMAT) && !have_conn |=> reg_rdata_ff == READ_NO_CONN;
  endproperty
  a_noconn_read: assert property (p_noconn_read) else $error("no connection read not 255"); // RL5

  property p_open;
    reg_wr && reg_addr == REG_FORMAT && !have_conn && reg_wdata < 32'h0000_0004
      |=> open_req_ff && have_conn && conn_fmt_ff == $past(reg_wdata[1:0]) ##1 !open_req_ff;
  endproperty
  a_open: assert property (p_open) else $error("format write did not open connection"); // RL8

  property p_range;
    reg_wr && reg_addr == REG_FORMAT && have_conn && reg_wdata != {30'h0, conn_fmt_ff}
      |=> range_err_ff && $stable(conn_fmt_ff);
  endproperty
  a_range: assert property (p_range) else $error("format mismatch not rejected"); // RL9

  property p_fmt_read;
    reg_rd && reg_addr == REG_FORMAT && have_conn |=> reg_rdata_ff[FMT_LINK_BIT] == $past(conn_up_ff);
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("link bit wrong"); // RL10

  property p_byte_step;
    reg_wr && reg_addr == REG_BYTE && have_conn |=> idx_ff == IDX_W'($past(idx_ff) + IDX_W'(1));
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte write index step wrong"); // RL15

  property p_long_step;
    reg_wr && reg_addr == REG_LONG && have_conn |=> idx_ff == IDX_W'($past(idx_ff) + IDX_W'(4));
  endproperty
  a_long_step: assert property (p_long_step) else $error("long write index step wrong"); // RL16

  property p_word_step;
    reg_wr && reg_addr == REG_WORD && have_conn |=> idx_ff == IDX_W'($past(idx_ff) + IDX_W'(2));
  endproperty
  a_word_step: assert property (p_word_step) else $error("word write index step wrong"); // RL16

  property p_index_set;
    reg_wr && reg_addr == REG_INDEX |=> idx_ff == $past(reg_wdata[IDX_W-1:0]);
  endproperty
  a_index_set: assert property (p_index_set) else $error("index write not taken"); // RL12

  property p_read_keeps;
    reg_rd && is_buf_reg |=> $stable(idx_ff);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("buffer read moved index"); // RL18

  property p_access_err;
    (reg_rd || reg_wr) && is_buf_reg && !have_conn |=> access_err_ff;
  endproperty
  a_access_err: assert property (p_access_err) else $error("access without connection not flagged"); // RL18

  c_launch_done: cover property (reg_wr && reg_addr == REG_LAUNCH ##[1:20] state_ff == ST_DONE);
  c_range: cover property (range_err_ff);
  c_long_write: cover property (reg_wr && reg_addr == REG_LONG && have_conn);
  c_open_up: cover property (open_req_ff ##[1:8] conn_up_ff);
  c_access_err: cover property (access_err_ff);
endmodule : embp_port
`default_nettype wire

// ### verif/embp_net_model.sv
`default_nettype none
// ----------------------------------------
// Remote node answering explicit requests
// ----------------------------------------
module embp_net_model (
  input wire logic clk,
  input wire logic send_req,
  input wire logic open_req,
  input wire logic [7:0] reply_len,
  input wire logic [7:0] reply_wait,
  input wire logic [7:0] tx_rdata,
  output logic send_done,
  output logic [7:0] rsp_len,
  output logic link_up,
  output logic rsp_we,
  output logic [7:0] rsp_addr,
  output logic [7:0] rsp_wdata,
  output logic [7:0] tx_raddr,
  output logic [7:0] hdr_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    send_done = 1'b0;
    rsp_len = 8'h00;
    link_up = 1'b0;
    rsp_we = 1'b0;
    rsp_addr = 8'h00;
    rsp_wdata = 8'h00;
    tx_raddr = 8'h00;
    hdr_seen = 8'h00;
    forever begin
      @(posedge clk);
      // Released lines toggle on each idle cycle so stale values cannot pass
      rsp_wdata <= ~rsp_wdata;
      rsp_len <= ~rsp_len;
      if (open_req) begin
        repeat (3) @(posedge clk);
        link_up <= 1'b1;
        @(posedge clk);
        link_up <= 1'b0;
      end else if (send_req) begin
        tx_raddr <= 8'h00;
        repeat (2) @(posedge clk);
        hdr_seen = tx_rdata;
        tx_raddr <= 8'h5a;
        for (int i = 1; i < int'(reply_len); i++) begin
          rsp_we <= 1'b1;
          rsp_addr <= i[7:0];
          rsp_wdata <= 8'h80 + i[7:0];
          @(posedge clk);
        end
        rsp_we <= 1'b0;
        repeat (reply_wait) @(posedge clk);
        send_done <= 1'b1;
        rsp_len <= reply_len;
        @(posedge clk);
        send_done <= 1'b0;
      end
    end
  end
endmodule : embp_net_model
`default_nettype wire

// ### verif/test_embp_port.sv
`default_nettype none
module test_embp_port
  import embp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst, reg_wr, reg_rd, send_req_ff, open_req_ff, range_err_ff, access_err_ff;
  logic send_done, link_up, rsp_we;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, send_num_ff, send_module_ff, open_module_ff;
  logic [1:0] open_fmt_ff;
  logic [7:0] rsp_len, rsp_addr, rsp_wdata, tx_raddr, tx_rdata_ff, reply_len, reply_wait, hdr_seen;
  int num_errors = 0;
  int num_checks = 0;

  embp_port #(.IDX_W(8)) u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .send_req_ff(send_req_ff),
    .send_num_ff(send_num_ff), .send_module_ff(send_module_ff), .open_req_ff(open_req_ff),
    .open_module_ff(open_module_ff), .open_fmt_ff(open_fmt_ff), .range_err_ff(range_err_ff),
    .access_err_ff(access_err_ff), .send_done(send_done), .rsp_len(rsp_len), .link_up(link_up),
    .rsp_we(rsp_we), .rsp_addr(rsp_addr), .rsp_wdata(rsp_wdata), .tx_raddr(tx_raddr),
    .tx_rdata_ff(tx_rdata_ff)
  );

  embp_net_model u_net (
    .clk(clk), .send_req(send_req_ff), .open_req(open_req_ff), .reply_len(reply_len),
    .reply_wait(reply_wait), .tx_rdata(tx_rdata_ff), .send_done(send_done), .rsp_len(rsp_len),
    .link_up(link_up), .rsp_we(rsp_we), .rsp_addr(rsp_addr), .rsp_wdata(rsp_wdata),
    .tx_raddr(tx_raddr), .hdr_seen(hdr_seen)
  );

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // Bus access and checking
  // ----------------------------------------
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask : rd

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdc

  task automatic wait_idle(input logic [31:0] e);
    logic [31:0] d;
    d = STAT_BUSY;
    for (int n = 0; n < 400 && d === STAT_BUSY; n++) begin
      rd(REG_LAUNCH, d);
    end
    if (d === STAT_BUSY) begin
      num_errors++;
      give_verdict();
    end
    chk(d, e);
  endtask : wait_idle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(REG_LAUNCH, READ_NO_CONN);
    rdc(REG_FORMAT, READ_NO_CONN);
    rdc(REG_INDEX, 32'h0000_0000);
    wr(REG_BYTE, 32'h0000_0011);
    chk(32'(access_err_ff), 32'h0000_0001);
    rdc(REG_BYTE, 32'h0000_0000);
    chk(32'(access_err_ff), 32'h0000_0001);
    rdc(REG_INDEX, 32'h0000_0000);
  endtask : t_reset

  task automatic t_store;
    wr(REG_DATA_FIRST, 32'h1111_2222);
    wr(REG_DATA_LAST, 32'h3333_4444);
    wr(16'h3400, 32'hffff_ffff);
    rdc(REG_DATA_FIRST, 32'h1111_2222);
    rdc(REG_DATA_LAST, 32'h3333_4444);
    rdc(16'h3400, 32'h0000_0000);
  endtask : t_store

  task automatic t_formats;
    int cl;
    int il;
    for (int c = 0; c < 4; c++) begin
      cl = (c == 2 || c == 3) ? 2 : 1;
      il = (c == 1 || c == 2) ? 2 : 1;
      wr(REG_MODULE, 32'h0000_0010 + c);
      rdc(REG_MODULE, 32'h0000_0010 + c);
      wr(REG_FORMAT, 32'(c));
      chk(32'(open_req_ff), 32'h0000_0001);
      chk(32'(open_fmt_ff), 32'(c));
      chk(open_module_ff, 32'h0000_0010 + c);
      rdc(REG_FORMAT, 32'(c));
      repeat (6) @(posedge clk);
      rdc(REG_FORMAT, 32'h0000_0100 + c);
      rdc(REG_LAUNCH, STAT_IDLE);
      wr(REG_SERVICE, 32'h0000_000e);
      rdc(REG_INDEX, 32'h0000_0002);
      wr(REG_CLASS, 32'h0000_0102);
      rdc(REG_INDEX, 32'(2 + cl));
      wr(REG_INSTANCE, 32'h0000_0304);
      rdc(REG_INDEX, 32'(2 + cl + il));
      rdc(REG_CLASS, cl == 2 ? 32'h0000_0102 : 32'h0000_0002);
      rdc(REG_INSTANCE, il == 2 ? 32'h0000_0304 : 32'h0000_0004);
    end
  endtask : t_formats

  task automatic t_range;
    wr(REG_MODULE, 32'h0000_0005);
    wr(REG_FORMAT, 32'h0000_0004);
    chk(32'(range_err_ff), 32'h0000_0001);
    chk(32'(open_req_ff), 32'h0000_0000);
    wr(REG_FORMAT, 32'h0000_0002);
    chk(32'(open_req_ff), 32'h0000_0001);
    repeat (6) @(posedge clk);
    wr(REG_FORMAT, 32'h0000_0001);
    chk(32'(range_err_ff), 32'h0000_0001);
    chk(32'(open_req_ff), 32'h0000_0000);
    rdc(REG_FORMAT, 32'h0000_0102);
    wr(REG_FORMAT, 32'h0000_0007);
    chk(32'(range_err_ff), 32'h0000_0001);
    wr(REG_FORMAT, 32'h0000_0002);
    chk(32'(range_err_ff), 32'h0000_0000);
    chk(32'(open_req_ff), 32'h0000_0000);
  endtask : t_range

  task automatic t_typed;
    wr(REG_INDEX, 32'h0000_0008);
    wr(REG_BYTE, 32'hffff_ff5a);
    rdc(REG_INDEX, 32'h0000_0009);
    wr(REG_WORD, 32'habcd_1234);
    rdc(REG_INDEX, 32'h0000_000b);
    wr(REG_LONG, 32'hdead_beef);
    rdc(REG_INDEX, 32'h0000_000f);
    wr(REG_INDEX, 32'h0000_0008);
    rdc(REG_BYTE, 32'h0000_005a);
    rdc(REG_INDEX, 32'h0000_0008);
    wr(REG_INDEX, 32'h0000_0009);
    rdc(REG_WORD, 32'h0000_1234);
    wr(REG_INDEX, 32'h0000_000a);
    rdc(REG_BYTE, 32'h0000_0012);
    wr(REG_INDEX, 32'h0000_000b);
    rdc(REG_LONG, 32'hdead_beef);
    wr(REG_INDEX, 32'h0000_00ff);
    wr(REG_BYTE, 32'h0000_0077);
    rdc(REG_INDEX, 32'h0000_0000);
  endtask : t_typed

  task automatic t_launch;
    for (int k = 0; k < 2; k++) begin
      reply_len <= (k == 1) ? 8'hfe : 8'h06;
      reply_wait <= (k == 1) ? 8'h1e : 8'h00;
      wr(REG_LAUNCH, 32'(7 + k));
      chk(32'(send_req_ff), 32'h0000_0001);
      chk(send_num_ff, 32'(7 + k));
      chk(send_module_ff, 32'h0000_0005);
      rdc(REG_LAUNCH, STAT_BUSY);
      wait_idle((k == 1) ? 32'h0000_00fe : 32'h0000_0006);
      chk(32'(hdr_seen), 32'h0000_0005);
      wr(REG_INDEX, 32'h0000_0001);
      rdc(REG_BYTE, 32'h0000_0081);
    end
  endtask : t_launch

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reply_len = 8'h06;
    reply_wait = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_store();
    t_formats();
    t_range();
    t_typed();
    t_launch();
    give_verdict();
  end
endmodule : test_embp_port
`default_nettype wire
